// ### pmawu_pkg.sv
package pmawu_pkg;
  ////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] idx_wake_csr  = 8'h48;
  localparam logic [7:0] idx_wake_pr   = 8'h49;
  localparam logic [7:0] idx_main_clk  = 8'h4a;
  localparam logic [7:0] idx_irq_stat  = 8'h4b;
  localparam logic [7:0] idx_irq_mask  = 8'h4c;
  // field positions
  localparam int csr_enable_pos = 0;
  localparam int csr_mode_pos   = 1;
  localparam int csr_flag_pos   = 2;
  localparam int mcc_slow_pos   = 0;
  localparam int ist_awu_pos    = 0;
  localparam int ist_wake_pos   = 1;
  // reset values
  localparam logic [7:0] wake_csr_rst = 8'h00;
  localparam logic [7:0] wake_pr_rst  = 8'hff;
  localparam logic [7:0] main_clk_rst = 8'h00;
  localparam logic [1:0] irq_reg_rst  = 2'h0;
  // timing
  localparam int slow_div       = 32;
  localparam int awu_mult       = 64;
  localparam int clk_period_ns  = 10;
  localparam int osc_startup_ns = 2000;
  localparam int osc_startup_cyc = (osc_startup_ns + clk_period_ns - 1) / clk_period_ns;
  // power states, gray in the order run -> wait -> halt -> wake -> run
  typedef enum logic [1:0] {
    st_run  = 2'b00,
    st_wait = 2'b01,
    st_halt = 2'b11,
    st_wake = 2'b10
  } pmawu_state_e;
  // byte address of a register index
  function automatic logic [31:0] pmawu_addr(input logic [7:0] idx);
    pmawu_addr = {22'h0, idx, 2'h0};
  endfunction : pmawu_addr
endpackage : pmawu_pkg

// ### pmawu_tmr_if.sv
`timescale 1ns/1ps
// control path between the power controller and the wakeup timer
interface pmawu_tmr_if;
  logic       start;
  logic       abort;
  logic [7:0] presc;
  logic       expired;
  logic       busy;
  modport ctl (output start, output abort, output presc, input expired, input busy);
  modport tmr (input start, input abort, input presc, output expired, output busy);
endinterface : pmawu_tmr_if

// ### pmawu_clkdiv.sv
`timescale 1ns/1ps
module pmawu_clkdiv #(
  parameter int div = pmawu_pkg::slow_div
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control and tick
  input  wire logic slow,
  output logic      tick
);
  logic [$clog2(div)-1:0] cnt;
  ////////////////////////////////////////////////////////////////////////
  // one tick per oscillator cycle, or one per div cycles in slow mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (!slow) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 1'b1;
      tick <= (cnt == '1);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  slow_gap_a: assert property (tick && slow |=> (!tick || !slow) [*8])
    else $error("slow tick came too soon");
  slow_period_a: assert property (tick && slow && $past(slow) |-> ##32 (tick || !$past(slow)))
    else $error("slow tick period wrong");
endmodule : pmawu_clkdiv

// ### pmawu_wake_timer.sv
`timescale 1ns/1ps
module pmawu_wake_timer #(
  parameter int startup_cyc = pmawu_pkg::osc_startup_cyc
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // wakeup oscillator, asynchronous to hclk
  input  wire logic awu_osc,
  // control
  pmawu_tmr_if.tmr  t
);
  logic [2:0]  osc_sync;
  logic        osc_level;
  logic [13:0] edges;
  logic [15:0] settle;
  logic        counting;
  logic        starting;
  logic        expired_q;
  logic        rise;
  ////////////////////////////////////////////////////////////////////////
  // three-stage sync; an edge counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_sync  <= 3'h0;
      osc_level <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[1:0], awu_osc};
      if (osc_sync[1] == osc_sync[2]) osc_level <= osc_sync[2];
    end
  end
  assign rise = osc_sync[1] && osc_sync[2] && !osc_level;
  ////////////////////////////////////////////////////////////////////////
  // 64 x prescaler oscillator periods, then the start-up delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edges     <= 14'h0;
      settle    <= 16'h0;
      counting  <= 1'b0;
      starting  <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      expired_q <= 1'b0;
      if (t.abort) begin
        counting <= 1'b0;
        starting <= 1'b0;
      end else if (t.start) begin
        edges    <= 14'h0;
        counting <= 1'b1;
      end else if (counting && rise) begin
        edges <= edges + 14'h1;
        if (edges + 14'h1 == {t.presc, 6'h0}) begin
          counting <= 1'b0;
          starting <= 1'b1;
          settle   <= 16'h0;
        end
      end else if (starting) begin
        settle <= settle + 16'h1;
        if (settle + 16'h1 >= 16'(startup_cyc)) begin
          starting  <= 1'b0;
          expired_q <= 1'b1;
        end
      end
    end
  end
  assign t.expired = expired_q;
  assign t.busy    = counting || starting;
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  expire_after_a: assert property (expired_q |-> $past(starting) && !counting)
    else $error("wakeup expired without start-up phase");
endmodule : pmawu_wake_timer

// ### pmawu_top.sv
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module pmawu_top #(
  parameter int startup_cyc = pmawu_pkg::osc_startup_cyc
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // cpu side
  input  wire logic        wfi_req,
  input  wire logic        halt_req,
  input  wire logic        irq_req,
  // wakeup oscillator pin
  input  wire logic        awu_osc,
  // clock enables and power status
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             cpu_stopped,
  output logic             slow_wait,
  // cpu control pulses
  output logic             clr_imask,
  output logic             pc_load,
  output logic             pc_vec_awu,
  // interrupt
  output logic             irq
);
  pmawu_pkg::pmawu_state_e state;
  pmawu_tmr_if             tif ();
  logic [7:0]              wake_csr;
  logic [7:0]              wake_pr;
  logic [7:0]              main_clk;
  logic [1:0]              irq_stat;
  logic [1:0]              irq_mask;
  logic                    div_tick;
  logic                    wr_pend;
  logic [7:0]              wr_idx;
  logic                    vec_awu;
  logic                    tmr_start;
  logic                    tmr_abort;
  logic                    ap_valid;
  logic                    rd_csr;
  logic                    ev_awu;
  logic                    ev_wake;

  ////////////////////////////////////////////////////////////////////////
  // register index of a bus address, 8'h00 when outside the map
  function automatic logic [7:0] reg_index(input logic [31:0] a);
    reg_index = (a[31:10] == 22'h0 && a[1:0] == 2'h0) ? a[9:2] : 8'h00;
  endfunction : reg_index

  // read value of a register index; unmapped reads as zero
  function automatic logic [31:0] reg_read(input logic [7:0] idx);
    case (idx)
      pmawu_pkg::idx_wake_csr: reg_read = {29'h0, wake_csr[2:0]};
      pmawu_pkg::idx_wake_pr:  reg_read = {24'h0, wake_pr};
      pmawu_pkg::idx_main_clk: reg_read = {31'h0, main_clk[pmawu_pkg::mcc_slow_pos]};
      pmawu_pkg::idx_irq_stat: reg_read = {30'h0, irq_stat};
      pmawu_pkg::idx_irq_mask: reg_read = {30'h0, irq_mask};
      default:                 reg_read = 32'h0;
    endcase
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////
  // submodules
  pmawu_clkdiv #(
    .div     (pmawu_pkg::slow_div)
  ) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .slow    (main_clk[pmawu_pkg::mcc_slow_pos]),
    .tick    (div_tick)
  );

  pmawu_wake_timer #(
    .startup_cyc (startup_cyc)
  ) u_tmr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .awu_osc (awu_osc),
    .t       (tif.tmr)
  );

  assign tif.start = tmr_start;
  assign tif.abort = tmr_abort;
  assign tif.presc = wake_pr;

  ////////////////////////////////////////////////////////////////////////
  // ahb address phase: zero wait states, reads sampled here
  assign ap_valid = hsel && htrans[1] && hready;
  assign rd_csr   = ap_valid && !hwrite && reg_index(haddr) == pmawu_pkg::idx_wake_csr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_idx    <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;   // always okay
      wr_pend   <= ap_valid && hwrite;
      if (ap_valid) begin
        wr_idx <= reg_index(haddr);
      end
      if (ap_valid && !hwrite) begin
        hrdata <= reg_read(reg_index(haddr));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wakeup control register: enable and mode writable, flag set by hw
  // flag clears on a read; a new expiry in that cycle still wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_csr <= pmawu_pkg::wake_csr_rst;
    end else begin
      if (wr_pend && wr_idx == pmawu_pkg::idx_wake_csr) begin
        wake_csr[pmawu_pkg::csr_enable_pos] <= hwdata[pmawu_pkg::csr_enable_pos];
        wake_csr[pmawu_pkg::csr_mode_pos]   <= hwdata[pmawu_pkg::csr_mode_pos];
      end
      if (ev_awu) begin
        wake_csr[pmawu_pkg::csr_flag_pos] <= 1'b1;
      end else if (rd_csr) begin
        wake_csr[pmawu_pkg::csr_flag_pos] <= 1'b0;
      end
      wake_csr[7:3] <= 5'h0;
    end
  end

  // prescaler: resets to maximum, zero writes dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_pr <= pmawu_pkg::wake_pr_rst;
    end else if (wr_pend && wr_idx == pmawu_pkg::idx_wake_pr && hwdata[7:0] != 8'h00) begin
      wake_pr <= hwdata[7:0];
    end
  end

  // main clock register; slow select takes effect on the divider at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_clk <= pmawu_pkg::main_clk_rst;
    end else if (wr_pend && wr_idx == pmawu_pkg::idx_main_clk) begin
      main_clk <= {7'h0, hwdata[pmawu_pkg::mcc_slow_pos]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear; set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= pmawu_pkg::irq_reg_rst;
      irq_mask <= pmawu_pkg::irq_reg_rst;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_pend && wr_idx == pmawu_pkg::idx_irq_stat) ?
                  hwdata[1:0] : 2'h0)) | {ev_wake, ev_awu};
      if (wr_pend && wr_idx == pmawu_pkg::idx_irq_mask) begin
        irq_mask <= hwdata[1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state machine
  assign ev_awu  = state == pmawu_pkg::st_halt && tif.expired;
  assign ev_wake = (state == pmawu_pkg::st_wait || state == pmawu_pkg::st_halt) &&
                   irq_req && !tif.expired;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= pmawu_pkg::st_run;
      tmr_start <= 1'b0;
      tmr_abort <= 1'b0;
      vec_awu   <= 1'b0;
    end else begin
      tmr_start <= 1'b0;
      tmr_abort <= 1'b0;
      case (state)
        pmawu_pkg::st_run: begin
          if (wfi_req) begin
            state <= pmawu_pkg::st_wait;
          end else if (halt_req) begin
            state     <= pmawu_pkg::st_halt;
            tmr_start <= wake_csr[pmawu_pkg::csr_enable_pos] &&
                         wake_csr[pmawu_pkg::csr_mode_pos];
          end
        end
        pmawu_pkg::st_wait: begin
          if (irq_req) begin
            state   <= pmawu_pkg::st_wake;
            vec_awu <= 1'b0;
          end
        end
        pmawu_pkg::st_halt: begin
          if (tif.expired) begin
            state   <= pmawu_pkg::st_wake;
            vec_awu <= 1'b1;
          end else if (irq_req) begin
            state     <= pmawu_pkg::st_wake;
            tmr_abort <= 1'b1;
            vec_awu   <= 1'b0;
          end
        end
        pmawu_pkg::st_wake: begin
          state <= pmawu_pkg::st_run;
        end
        default: begin
          state <= pmawu_pkg::st_run;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cpu controls; peripherals keep their enable in wait, not in halt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
      cpu_stopped   <= 1'b0;
      slow_wait     <= 1'b0;
      clr_imask     <= 1'b0;
      pc_load       <= 1'b0;
      pc_vec_awu    <= 1'b0;
    end else begin
      cpu_clk_en    <= div_tick && state == pmawu_pkg::st_run;
      periph_clk_en <= div_tick && state != pmawu_pkg::st_halt;
      cpu_stopped   <= state == pmawu_pkg::st_wait || state == pmawu_pkg::st_halt;
      slow_wait     <= state == pmawu_pkg::st_wait &&
                       main_clk[pmawu_pkg::mcc_slow_pos];
      // only the mask bit is touched on wait entry; the pulse lines up with
      // cpu_stopped so the cpu sees both on the same edge
      clr_imask     <= state == pmawu_pkg::st_wait && !cpu_stopped;
      pc_load       <= state == pmawu_pkg::st_wake;
      pc_vec_awu    <= state == pmawu_pkg::st_wake && vec_awu;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  presc_nonzero_a: assert property (wake_pr != 8'h00)
    else $error("prescaler holds zero");
  presc_zero_keep_a: assert property (wr_pend && wr_idx == pmawu_pkg::idx_wake_pr &&
      hwdata[7:0] == 8'h00 |=> $stable(wake_pr))
    else $error("zero write changed prescaler");
  presc_load_a: assert property (wr_pend && wr_idx == pmawu_pkg::idx_wake_pr &&
      hwdata[7:0] != 8'h00 |=> wake_pr == $past(hwdata[7:0]))
    else $error("prescaler write lost");
  csr_upper_a: assert property (wake_csr[7:3] == 5'h0 ##1 hrdata[31:3] == 29'h0 ||
      !$past(rd_csr))
    else $error("control upper bits not zero");
  wait_enter_a: assert property (state == pmawu_pkg::st_run && wfi_req |=>
      state == pmawu_pkg::st_wait ##1 clr_imask && cpu_stopped)
    else $error("wait entry wrong");
  wait_hold_a: assert property (state == pmawu_pkg::st_wait && !irq_req |=>
      state == pmawu_pkg::st_wait)
    else $error("left wait without interrupt");
  wait_wake_a: assert property (state == pmawu_pkg::st_wait && irq_req |=>
      ##1 pc_load && !pc_vec_awu)
    else $error("no vector load after wait");
  slow_wait_a: assert property (state == pmawu_pkg::st_wait &&
      main_clk[pmawu_pkg::mcc_slow_pos] |=> slow_wait)
    else $error("slow-wait not shown");
  periph_wait_a: assert property (state == pmawu_pkg::st_wait && div_tick |=>
      periph_clk_en && !cpu_clk_en)
    else $error("peripheral clock stopped in wait");
  awu_flag_a: assert property (ev_awu |=> wake_csr[pmawu_pkg::csr_flag_pos] ##1
      pc_load && pc_vec_awu)
    else $error("auto-wakeup flag or vector missing");
  irq_out_a: assert property (|(irq_stat & irq_mask) |=> irq)
    else $error("interrupt output low");
  imask_pulse_a: assert property (clr_imask |=> !clr_imask && cpu_stopped)
    else $error("mask clear pulse too long");

  wait_wake_c: cover property (state == pmawu_pkg::st_wait ##1
      state == pmawu_pkg::st_wake);
  awu_wake_c: cover property (ev_awu ##2 pc_vec_awu);
  slow_wait_c: cover property (slow_wait && periph_clk_en);
  zero_write_c: cover property (wr_pend && wr_idx == pmawu_pkg::idx_wake_pr &&
      hwdata[7:0] == 8'h00);
endmodule : pmawu_top

// ### pmawu_bench.sv
`timescale 1ns/1ps
module pmawu_bench;
  typedef struct {
    logic v;
    int   lo;
    int   hi;
  } pmawu_note_s;
  ////////////////////////////////////////////////////////////////////////
  // design ports and bench state
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        wfi_req;
  logic        halt_req;
  logic        irq_req;
  logic        awu_osc;
  logic        cpu_clk_en;
  logic        periph_clk_en;
  logic        cpu_stopped;
  logic        slow_wait;
  logic        clr_imask;
  logic        pc_load;
  logic        pc_vec_awu;
  logic        irq;
  logic        win;
  logic        win_d;
  logic        rd_pend;
  logic [31:0] lfsr_state;
  logic [32:0] rdq[$];
  pmawu_note_s cq[$];
  pmawu_note_s pq[$];
  pmawu_note_s tq[$];
  int          failures;
  int          tests_run;
  int          ca;
  int          cb;
  int          cyc;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // short start-up keeps each auto-wakeup run brief
  pmawu_top #(.startup_cyc(2)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wfi_req(wfi_req),
    .halt_req(halt_req), .irq_req(irq_req), .awu_osc(awu_osc),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .cpu_stopped(cpu_stopped), .slow_wait(slow_wait), .clr_imask(clr_imask),
    .pc_load(pc_load), .pc_vec_awu(pc_vec_awu), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // main clock, 10 ns
  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end

  // wakeup oscillator, 60 ns, phase unrelated to hclk
  initial begin
    awu_osc = 1'h0;
    #7;
    forever #30 awu_osc = ~awu_osc;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one whole-word transfer; a read leaves its expected value for the monitor
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [7:0] exp, input logic exp_irq);
    hsel   <= 1'h1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    if (!wr) rdq.push_back({exp_irq, 24'h0, exp});
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
  endtask : bus

  // one-cycle request: 0 wait, 1 halt, 2 interrupt
  task automatic cpu_req(input int which);
    if (which == 0) wfi_req <= 1'h1;
    else if (which == 1) halt_req <= 1'h1;
    else irq_req <= 1'h1;
    @(posedge hclk);
    wfi_req  <= 1'h0;
    halt_req <= 1'h0;
    irq_req  <= 1'h0;
  endtask : cpu_req

  // 320-cycle window holds a whole number of slow periods, so phase does not matter
  task automatic ticks(input int c, input int p);
    tq.push_back('{1'h0, c, p});
    win <= 1'h1;
    repeat (320) @(posedge hclk);
    win <= 1'h0;
    @(posedge hclk);
  endtask : ticks

  task automatic close_out();
    chk("notes left", 33'h0, 33'(rdq.size() + cq.size() + pq.size() + tq.size()));
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////
  // monitor: takes the oldest note whenever a result shows at the ports
  always @(posedge hclk) begin
    pmawu_note_s n;
    if (rd_pend) begin
      chk("read data", rdq.pop_front(), {irq, hrdata});
      chk("read response", 33'h0, {32'h0, hresp});
    end
    rd_pend = hresetn & hsel & htrans[1] & hready & !hwrite;
    // clr_imask pulses only on wait entry, one note per entry
    if (clr_imask === 1'h1 && cq.size() > 0) begin
      n = cq.pop_front();
      chk("slow wait", {32'h0, n.v}, {32'h0, slow_wait});
      chk("cpu stopped", 33'h1, {32'h0, cpu_stopped});
    end
    if (pc_load === 1'h1) begin
      n = (pq.size() > 0) ? pq.pop_front() : '{1'hx, 0, -1};
      chk("wake vector", {32'h0, n.v}, {32'h0, pc_vec_awu});
      chk("wake time", 33'h1, {32'h0, cyc >= n.lo && cyc <= n.hi});
    end
    cyc = (wfi_req | halt_req | irq_req) ? 0 : cyc + 1;
    if (win) begin
      ca += int'(cpu_clk_en === 1'h1);
      cb += int'(periph_clk_en === 1'h1);
    end else if (win_d) begin
      n = tq.pop_front();
      chk("cpu ticks", 33'(n.lo), 33'(ca));
      chk("periph ticks", 33'(n.hi), 33'(cb));
      ca = 0;
      cb = 0;
    end
    win_d = win;
  end

  // watchdog: whole run is under 8000 cycles
  initial begin
    #300000;
    failures++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////
  // driver
  initial begin
    logic [7:0]  pr;
    logic [31:0] v;
    int          i;
    hresetn    = 1'h0;
    hsel       = 1'h0;
    hwrite     = 1'h0;
    htrans     = 2'h0;
    haddr      = 32'h0;
    hwdata     = 32'h0;
    wfi_req    = 1'h0;
    halt_req   = 1'h0;
    irq_req    = 1'h0;
    win        = 1'h0;
    win_d      = 1'h0;
    rd_pend    = 1'h0;
    failures   = 0;
    tests_run  = 0;
    ca         = 0;
    cb         = 0;
    cyc        = 0;
    lfsr_state = 32'h4498;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(1'h0, pmawu_pkg::idx_wake_pr, 32'h0, 8'hff, 1'h0);
    bus(1'h0, pmawu_pkg::idx_wake_csr, 32'h0, 8'h00, 1'h0);
    bus(1'h1, pmawu_pkg::idx_wake_csr, 32'hffff_ffff, 8'h00, 1'h0);
    bus(1'h0, pmawu_pkg::idx_wake_csr, 32'h0, 8'h03, 1'h0);
    bus(1'h0, 8'h50, 32'h0, 8'h00, 1'h0);
    // random prescaler values, one forced to zero, which must be ignored
    pr = 8'hff;
    for (i = 0; i < 6; i++) begin
      lfsr_state = lfsr_next(lfsr_state);
      v = (i == 2) ? {lfsr_state[31:8], 8'h00} : lfsr_state;
      if (v[7:0] != 8'h00) pr = v[7:0];
      bus(1'h1, pmawu_pkg::idx_wake_pr, v, 8'h00, 1'h0);
      bus(1'h0, pmawu_pkg::idx_wake_pr, 32'h0, pr, 1'h0);
    end
    ticks(320, 320);
    bus(1'h1, pmawu_pkg::idx_main_clk, 32'h1, 8'h00, 1'h0);
    repeat (40) @(posedge hclk);
    ticks(10, 10);
    cq.push_back('{1'h1, 0, 0});
    cpu_req(0);
    repeat (4) @(posedge hclk);
    ticks(0, 10);
    pq.push_back('{1'h0, 0, 6});
    cpu_req(2);
    repeat (8) @(posedge hclk);
    // wake-by-interrupt status: masked, unmasked, then cleared
    bus(1'h0, pmawu_pkg::idx_irq_stat, 32'h0, 8'h02, 1'h0);
    bus(1'h1, pmawu_pkg::idx_irq_mask, 32'h2, 8'h00, 1'h0);
    bus(1'h0, pmawu_pkg::idx_irq_stat, 32'h0, 8'h02, 1'h1);
    bus(1'h1, pmawu_pkg::idx_irq_stat, 32'h2, 8'h00, 1'h0);
    bus(1'h0, pmawu_pkg::idx_irq_stat, 32'h0, 8'h00, 1'h0);
    bus(1'h1, pmawu_pkg::idx_main_clk, 32'h0, 8'h00, 1'h0);
    // auto-wakeup with factors 1 and 3; one osc period is 6 hclk cycles
    for (i = 1; i < 4; i += 2) begin
      bus(1'h1, pmawu_pkg::idx_wake_pr, 32'(i), 8'h00, 1'h0);
      pq.push_back('{1'h1, 384 * i - 8, 384 * i + 24});
      cpu_req(1);
      while (pc_load !== 1'h1) @(posedge hclk);
      repeat (4) @(posedge hclk);
      bus(1'h0, pmawu_pkg::idx_wake_csr, 32'h0, 8'h07, 1'h0);
      bus(1'h0, pmawu_pkg::idx_wake_csr, 32'h0, 8'h03, 1'h0);
      bus(1'h0, pmawu_pkg::idx_irq_stat, 32'h0, 8'h01, 1'h0);
      bus(1'h1, pmawu_pkg::idx_irq_stat, 32'h1, 8'h00, 1'h0);
    end
    repeat (4) @(posedge hclk);
    close_out();
  end
endmodule : pmawu_bench
